/* File: design/fspi_ctrl.sv */
// Five-source interrupt controller with four levels and nesting
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "fspi_regs.svh"

module fspi_ctrl (
	// Clock, reset and clock enable
	// While ce is low every flip-flop holds, the bus ack included
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               ce,

	// Classic Wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output var  logic [31:0]        wb_dat_o,
	output var  logic               wb_ack_o,

	// External request pins, active low, asynchronous
	input  wire logic               ext_req_line0_n,
	input  wire logic               ext_req_line1_n,

	// On-chip peripheral requests, same clock, active high
	input  wire logic               tmr0_ovf_req,
	input  wire logic               tmr1_ovf_req,
	input  wire logic               serial_req,

	// Core side
	output var  fspi_pkg::fspi_core_t core_irq,
	input  wire logic               core_vec_take,
	input  wire logic               core_ret
);

	// Two-stage synchronisers for the external pins
	logic [1:0] ext_meta_q;
	logic [1:0] ext_sync_q;

	// Software-visible state
	logic [7:0] irq_enable_mask_q;
	logic [4:0] prio_low_bits_q;
	logic [4:0] prio_high_bits_q;

	// One bit per level with a routine in service
	logic [3:0] isvc_q;
	logic [3:0] isvc_d;

	// Registered core outputs
	fspi_pkg::fspi_core_t core_q;
	fspi_pkg::fspi_core_t core_d;

	// Bus answer registers
	logic        ack_q;
	logic [31:0] rdat_q;

	// Named enable fields
	wire global_irq_enable;
	wire serial_irq_mask_bit;
	wire tmr1_ovf_irq_en;
	wire ext_line1_irq_en;
	wire tmr0_ovf_irq_en;
	wire ext_line0_irq_en;

	assign global_irq_enable   = irq_enable_mask_q[`FSPI_EN_GLOBAL];
	assign serial_irq_mask_bit = irq_enable_mask_q[`FSPI_EN_SERIAL];
	assign tmr1_ovf_irq_en     = irq_enable_mask_q[`FSPI_EN_TMR1];
	assign ext_line1_irq_en    = irq_enable_mask_q[`FSPI_EN_EXT1];
	assign tmr0_ovf_irq_en     = irq_enable_mask_q[`FSPI_EN_TMR0];
	assign ext_line0_irq_en    = irq_enable_mask_q[`FSPI_EN_EXT0];

	// Per-source vectors, indexed by source code
	wire [4:0] src_pend;
	wire [4:0] src_en;

	// Pins are active low; the synchronised level is inverted here
	// All requests are levels; clearing them is the peripheral's job
	assign src_pend[`FSPI_EN_EXT0]   = ~ext_sync_q[0];
	assign src_pend[`FSPI_EN_TMR0]   = tmr0_ovf_req;
	assign src_pend[`FSPI_EN_EXT1]   = ~ext_sync_q[1];
	assign src_pend[`FSPI_EN_TMR1]   = tmr1_ovf_req;
	assign src_pend[`FSPI_EN_SERIAL] = serial_req;

	assign src_en[`FSPI_EN_EXT0]   = ext_line0_irq_en;
	assign src_en[`FSPI_EN_TMR0]   = tmr0_ovf_irq_en;
	assign src_en[`FSPI_EN_EXT1]   = ext_line1_irq_en;
	assign src_en[`FSPI_EN_TMR1]   = tmr1_ovf_irq_en;
	assign src_en[`FSPI_EN_SERIAL] = serial_irq_mask_bit;

	// Highest level now in service, plus a flag for none
	wire            isvc_any;
	fspi_pkg::fspi_lvl_t isvc_top;

	assign isvc_any = |isvc_q;
	// Bit 0 needs no test: with nothing above set the top is level 0
	assign isvc_top = isvc_q[3] ? 2'h3 :
	                  isvc_q[2] ? 2'h2 :
	                  isvc_q[1] ? 2'h1 : 2'h0;

	// Rank 0 means idle; a level ranks one above its code
	wire [2:0] isvc_rank;
	assign isvc_rank = isvc_any ? ({1'b0, isvc_top} + 3'h1) : 3'h0;

	// Per-source level and eligibility
	fspi_pkg::fspi_lvl_t src_lvl [`FSPI_NSRC];
	wire [4:0]           src_ok;
	wire [3:0]           lvl_hit [`FSPI_NSRC];

	genvar gi;
	generate
		for (gi = 0; gi < `FSPI_NSRC; gi++) begin : g_src
			// High bit is the upper level bit
			assign src_lvl[gi] = {prio_high_bits_q[gi], prio_low_bits_q[gi]};
			// Masked per source and globally, then must outrank the routine
			// An equal level never outranks, so a same-level request waits
			assign src_ok[gi]  = src_pend[gi] & src_en[gi] & global_irq_enable
			                   & (({1'b0, src_lvl[gi]} + 3'h1) > isvc_rank);
			// One-hot level of this source when it is eligible
			assign lvl_hit[gi] = src_ok[gi] ? (4'h1 << src_lvl[gi]) : 4'h0;
		end
	endgenerate

	// Which levels hold at least one eligible source
	// Plain reduction across sources; their order does not matter here
	logic [3:0] lvl_any;
	always_comb begin
		lvl_any = 4'h0;
		for (int i = 0; i < `FSPI_NSRC; i++) begin
			lvl_any = lvl_any | lvl_hit[i];
		end
	end

	// Winning level: the highest with an eligible source
	wire                 win_any;
	fspi_pkg::fspi_lvl_t win_lvl;

	assign win_any = |lvl_any;
	assign win_lvl = lvl_any[3] ? 2'h3 :
	                 lvl_any[2] ? 2'h2 :
	                 lvl_any[1] ? 2'h1 : 2'h0;

	// Inside the winning level, the lowest source code is polled first
	// Loop runs downward so the lowest matching index is the last write
	fspi_pkg::fspi_src_t win_src;
	always_comb begin
		win_src = fspi_pkg::FSPI_SRC_EXT0;
		for (int i = `FSPI_NSRC - 1; i >= 0; i--) begin
			if (src_ok[i] && (src_lvl[i] == win_lvl)) begin
				win_src = fspi_pkg::fspi_src_t'(i[2:0]);
			end
		end
	end

	// Next core output: request plus source are always paired
	always_comb begin
		core_d.req = win_any;
		core_d.src = win_any ? win_src : core_q.src;
	end

	// Core takes the vector only while a request is shown
	// A take against a dropped request would mark a level nobody entered
	wire take_ok;
	assign take_ok = core_vec_take & core_q.req;

	// Level of the source the core is taking
	fspi_pkg::fspi_lvl_t take_lvl;
	assign take_lvl = src_lvl[core_q.src];

	// Return retires the highest in-service level
	// A return with nothing in service changes nothing
	wire [3:0] ret_clr;
	assign ret_clr = (core_ret && isvc_any) ? (4'h1 << isvc_top) : 4'h0;

	// New routine's level marked; a take beats a return in one cycle
	// Only one level can enter per cycle, which matches one take pulse
	wire [3:0] take_set;
	assign take_set = take_ok ? (4'h1 << take_lvl) : 4'h0;

	always_comb begin
		isvc_d = (isvc_q & ~ret_clr) | take_set;
	end

	// Register addresses held as constants so their word part can be sliced
	localparam logic [7:0] ADR_ENABLE  = `FSPI_ADR_ENABLE;
	localparam logic [7:0] ADR_PRIO_LO = `FSPI_ADR_PRIO_LO;
	localparam logic [7:0] ADR_PRIO_HI = `FSPI_ADR_PRIO_HI;
	localparam logic [7:0] ADR_STATUS  = `FSPI_ADR_STATUS;

	// Address decode on word addresses; the byte-lane bits never decide
	fspi_pkg::fspi_dec_t dec;
	wire [5:0]           wadr;

	assign wadr            = wb_adr_i[7:`FSPI_WORD_LSB];
	assign dec.hit_enable  = wadr == ADR_ENABLE[7:`FSPI_WORD_LSB];
	assign dec.hit_prio_lo = wadr == ADR_PRIO_LO[7:`FSPI_WORD_LSB];
	assign dec.hit_prio_hi = wadr == ADR_PRIO_HI[7:`FSPI_WORD_LSB];
	assign dec.hit_status  = wadr == ADR_STATUS[7:`FSPI_WORD_LSB];

	// A new access starts once; ack drops in the cycle after it is given
	// A master that keeps stb up after ack gets a fresh access a cycle later
	wire bus_go;
	wire bus_wr;

	assign bus_go = wb_cyc_i & wb_stb_i & ~ack_q;
	assign bus_wr = bus_go & wb_we_i & wb_sel_i[0];

	// Reserved enable bits 6 and 5 are not stored; software must not set them
	// Ones written there are harmless: they never reach a flip-flop
	wire [7:0] en_wmask;
	assign en_wmask = `FSPI_EN_WMASK;

	// Read data; unmapped addresses answer with zero
	logic [31:0] rdat_d;
	always_comb begin
		rdat_d = 32'h0000_0000;
		if (dec.hit_enable) begin
			rdat_d[7:0] = irq_enable_mask_q;
		end else if (dec.hit_prio_lo) begin
			rdat_d[4:0] = prio_low_bits_q;
		end else if (dec.hit_prio_hi) begin
			rdat_d[4:0] = prio_high_bits_q;
		end else if (dec.hit_status) begin
			// Read-only view; a write here is acked and dropped
			rdat_d[`FSPI_ST_PEND_LSB +: 5] = src_pend;
			rdat_d[`FSPI_ST_ISVC_LSB +: 4] = isvc_q;
		end
	end

	// Pin synchroniser; the first stage feeds only the second
	// Reset to the idle high level, so no false request follows reset
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_meta_q <= `FSPI_RST_SYNC;
			ext_sync_q <= `FSPI_RST_SYNC;
		end else if (ce) begin
			ext_meta_q <= {ext_req_line1_n, ext_req_line0_n};
			ext_sync_q <= ext_meta_q;
		end
	end

	// Enable register: cleared by reset, reserved bits dropped
	// A write with sel[0] low is acked but leaves the register alone
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_enable_mask_q <= `FSPI_RST_ENABLE;
		end else if (ce && bus_wr && dec.hit_enable) begin
			irq_enable_mask_q <= wb_dat_i[7:0] & en_wmask;
		end
	end

	// Priority low and high bits
	always_ff @(posedge clk) begin
		if (rst) begin
			prio_low_bits_q  <= `FSPI_RST_PRIO;
			prio_high_bits_q <= `FSPI_RST_PRIO;
		end else if (ce && bus_wr) begin
			if (dec.hit_prio_lo) begin
				prio_low_bits_q <= wb_dat_i[4:0];
			end
			if (dec.hit_prio_hi) begin
				prio_high_bits_q <= wb_dat_i[4:0];
			end
		end
	end

	// Bus answer: one wait state, data captured with the ack
	// The wait state buys a registered read path at the cost of a cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (ce) begin
			ack_q  <= bus_go;
			rdat_q <= bus_go ? rdat_d : rdat_q;
		end
	end

	// Nesting state
	// One bit per level lets a routine be interrupted up to three deep
	always_ff @(posedge clk) begin
		if (rst) begin
			isvc_q <= `FSPI_RST_ISVC;
		end else if (ce) begin
			isvc_q <= isvc_d;
		end
	end

	// Core request and source, registered so they change together
	// Registering costs a cycle of latency but keeps glitches off the core
	always_ff @(posedge clk) begin
		if (rst) begin
			core_q.req <= 1'b0;
			core_q.src <= fspi_pkg::fspi_src_t'(`FSPI_RST_SRC);
		end else if (ce) begin
			// Drop the request in the cycle the vector is taken,
			// so the core never sees the same grant twice
			core_q.req <= core_d.req & ~take_ok;
			core_q.src <= core_d.src;
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign core_irq = core_q;

endmodule // fspi_ctrl

`default_nettype wire

/* File: design/fspi_pkg.sv */
// Types shared by the five-source priority interrupt controller
package fspi_pkg;

	// Source identity; the code equals the enable bit position
	typedef enum logic [2:0] {
		FSPI_SRC_EXT0   = 3'h0,
		FSPI_SRC_TMR0   = 3'h1,
		FSPI_SRC_EXT1   = 3'h2,
		FSPI_SRC_TMR1   = 3'h3,
		FSPI_SRC_SERIAL = 3'h4
	} fspi_src_t;

	// Two-bit priority level, 0 lowest and 3 highest
	typedef logic [1:0] fspi_lvl_t;

	// What the core sees: one request and the chosen source
	typedef struct packed {
		logic      req;
		fspi_src_t src;
	} fspi_core_t;

	// One decoded register access from the bus
	typedef struct packed {
		logic       hit_enable;
		logic       hit_prio_lo;
		logic       hit_prio_hi;
		logic       hit_status;
	} fspi_dec_t;

endpackage

/* File: design/fspi_regs.svh */
// Register offsets, field positions and reset values of the interrupt controller
// Operation
// - Five sources, each with own vector
// - Per-source enable bit gates each request
// - Global enable bit 7 blocks everything
// - Enable bit per source in fixed positions
// - Four levels from low and high bits
// - Level is high bit over low bit
// - Only higher level preempts running routine
// - Level-three routine is never preempted
// - Simultaneous requests: higher level wins
// - Equal levels: fixed polling order decides
// - Enable register at A8h, resets cleared
`ifndef FSPI_REGS_SVH
`define FSPI_REGS_SVH

// Bus geometry
`define FSPI_ADR_W        8
`define FSPI_WORD_LSB     2

// Byte addresses of the registers
`define FSPI_ADR_ENABLE   8'ha8
`define FSPI_ADR_PRIO_LO  8'hb8
`define FSPI_ADR_PRIO_HI  8'hbc
`define FSPI_ADR_STATUS   8'hc0

// Enable register layout
`define FSPI_EN_GLOBAL    7
`define FSPI_EN_SERIAL    4
`define FSPI_EN_TMR1      3
`define FSPI_EN_EXT1      2
`define FSPI_EN_TMR0      1
`define FSPI_EN_EXT0      0
`define FSPI_EN_WMASK     8'h9f

// Source count and level geometry
`define FSPI_NSRC         5
`define FSPI_NLVL         4

// Status register layout
`define FSPI_ST_PEND_LSB  0
`define FSPI_ST_ISVC_LSB  8

// Reset values
`define FSPI_RST_ENABLE   8'h00
`define FSPI_RST_PRIO     5'h00
`define FSPI_RST_ISVC     4'h0
`define FSPI_RST_SRC      3'h0
`define FSPI_RST_SYNC     2'h3

`endif

/* File: tb/fspi_core_model.sv */
// Behavioural core that takes vectors and returns from routines
`timescale 1ns/1ps
`default_nettype none
module fspi_core_model (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// Controller side
	input wire fspi_pkg::fspi_core_t core_irq,
	output logic                     core_vec_take,
	output logic                     core_ret,
	// Bench control: answer latency and return command
	input wire logic [3:0]           lat,
	input wire logic                 ret_cmd
);
	logic [3:0] wait_q;  // Cycles the request has stood unanswered
	// One-cycle take pulse, so one grant is never taken twice
	always_ff @(posedge clk) begin
		if (rst || !core_irq.req || core_vec_take)
			wait_q <= 4'h0;
		else
			wait_q <= wait_q + 4'h1;
		core_vec_take <= !rst && !core_vec_take && core_irq.req && wait_q >= lat;
		core_ret <= !rst && ret_cmd;
	end
endmodule // fspi_core_model
`default_nettype wire

/* File: tb/fspi_ctrl_checker.sv */
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "fspi_regs.svh"
module fspi_ctrl_checker (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 ce,
	// Register bus
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [7:0]           wb_adr_i,
	input wire logic [3:0]           wb_sel_i,
	input wire logic [31:0]          wb_dat_i,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	// Core side
	input wire fspi_pkg::fspi_core_t core_irq,
	input wire logic                 core_vec_take
);
	logic [7:0] en_q;                             // Shadow of the enable register
	logic [7:0] en_p;                             // Shadow as core_irq last saw it
	wire  [7:0] adr    = {wb_adr_i[7:2], 2'h0};   // Low address bits are ignored
	wire        hit_en = adr == `FSPI_ADR_ENABLE;
	wire        hit_pr = adr == `FSPI_ADR_PRIO_LO || adr == `FSPI_ADR_PRIO_HI;
	wire        mapped = hit_en || hit_pr || adr == `FSPI_ADR_STATUS;
	wire        rd_ack = wb_ack_o && !wb_we_i;    // Read answer cycle
	wire        taken  = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Shadow follows the taking edge; reserved bits never stick
	always_ff @(posedge clk) begin
		if (rst) begin
			en_q <= 8'h00;
			en_p <= 8'h00;
		end else begin
			if (taken && wb_we_i && wb_sel_i[0] && hit_en)
				en_q <= wb_dat_i[7:0] & `FSPI_EN_WMASK;
			en_p <= en_q;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// A request that the slave takes this edge
	sequence bus_req_s;
		taken;
	endsequence
	ack_one_wait_a: assert property (bus_req_s |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	enable_read_a: assert property (rd_ack && hit_en |-> wb_dat_o == {24'h00_0000, en_q})
		else $error("enable read value wrong");
	unmapped_zero_a: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	global_gate_a: assert property (core_irq.req |-> en_p[7])
		else $error("request with global enable clear");
	source_gate_a: assert property (core_irq.req |-> en_p[core_irq.src])
		else $error("request from masked source");
	source_legal_a: assert property (core_irq.req |-> core_irq.src <= 3'h4)
		else $error("source code out of range");
	take_drop_a: assert property (ce && core_vec_take && core_irq.req |=> !core_irq.req)
		else $error("request stands after take");
endmodule // fspi_ctrl_checker
bind fspi_ctrl fspi_ctrl_checker fspi_ctrl_checker_inst (.clk, .rst, .ce, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.core_irq, .core_vec_take);
`default_nettype wire

/* File: tb/fspi_ctrl_tb.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module fspi_ctrl_tb;
	// One case: enable, low and high priority bits, requests, granted source
	typedef struct packed {
		logic [7:0] en, lo, hi;
		logic [4:0] rq;
		logic [2:0] src;
	} fspi_row_t;
	logic                 clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ret_cmd = 0;
	logic                 ack, take, ret;
	logic                 ce = 1;      // Clock enable; low freezes the block
	logic [7:0]           adr = 8'h00;
	logic [31:0]          wdat = 32'h0000_0000, rdat, rd;
	logic [4:0]           rq = 5'h00;  // Request per source code
	logic [3:0]           lat = 4'h0;  // Core answer delay
	fspi_pkg::fspi_core_t irq;
	int                   fail_count = 0, tests_run = 0;
	fspi_row_t rows [9] = '{
		{8'h9f, 8'h00, 8'h00, 5'h1f, 3'h0}, {8'h9f, 8'h10, 8'h00, 5'h1f, 3'h4},
		{8'h9f, 8'h04, 8'h08, 5'h1f, 3'h3}, {8'h9f, 8'h0c, 8'h0c, 5'h1f, 3'h2},
		{8'h94, 8'h00, 8'h00, 5'h1f, 3'h2}, {8'h82, 8'h00, 8'h00, 5'h1f, 3'h1},
		{8'h88, 8'h00, 8'h00, 5'h1f, 3'h3}, {8'h90, 8'h00, 8'h00, 5'h1f, 3'h4},
		{8'h81, 8'h00, 8'h00, 5'h1f, 3'h0}};
	// Sel is tied to byte 0, where all writable registers live
	fspi_ctrl fspi_ctrl_inst (.clk, .rst, .ce, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_req_line0_n(~rq[0]), .ext_req_line1_n(~rq[2]),
		.tmr0_ovf_req(rq[1]), .tmr1_ovf_req(rq[3]), .serial_req(rq[4]),
		.core_irq(irq), .core_vec_take(take), .core_ret(ret));
	fspi_core_model fspi_core_model_inst (.clk, .rst, .core_irq(irq),
		.core_vec_take(take), .core_ret(ret), .lat, .ret_cmd);
	initial forever #2.5 clk = ~clk;
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rd = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	// Next vector the core takes must come from source s
	task automatic see_take(input logic [2:0] s);
		for (int i = 0; i < 40 && !(take === 1'b1 && irq.req === 1'b1); i++)
			@(negedge clk);
		chk({28'h0, take, irq.src}, {28'h0, 1'b1, s});
		@(posedge clk);
	endtask
	// Nothing may be taken for a while
	task automatic no_take;
		logic got;
		got = 0;
		repeat (12) begin
			@(negedge clk);
			got |= take;
		end
		chk({31'h0, got}, 32'h0);
		@(posedge clk);
	endtask
	// Core returns from its routine: one ret_cmd pulse, then three idle cycles
	task automatic rtn;
		@(posedge clk);
		ret_cmd <= 1;
		@(posedge clk);
		ret_cmd <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic stop_test;
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		// Requests settle through the pin sync before enables open
		foreach (rows[i]) begin
			lat <= i[0] ? 4'h5 : 4'h0;
			wb(1, 8'ha8, 32'h0);
			wb(1, 8'hb8, 32'(rows[i].lo));
			wb(1, 8'hbc, 32'(rows[i].hi));
			rq <= rows[i].rq;
			repeat (4) @(posedge clk);
			wb(1, 8'ha8, 32'(rows[i].en));
			see_take(rows[i].src);
			@(posedge clk);
			rq <= 5'h00;
			repeat (6) @(posedge clk);
			rtn;
		end
		// Mid-run reset clears registers; unmapped reads give zero
		rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		wb(0, 8'ha8, 32'h0);
		chk(rd, 32'h0);
		wb(0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		wb(1, 8'ha8, 32'h1f);
		wb(0, 8'ha8, 32'h0);
		chk(rd, 32'h1f);
		rq <= 5'h02;
		no_take;
		wb(1, 8'ha8, 32'h9f);
		see_take(3'h1);
		rq <= 5'h00;
		repeat (6) @(posedge clk);
		rtn;
		// Nesting: tmr0 and serial at level 1, ext1 at level 3
		wb(1, 8'hb8, 32'h16);
		wb(1, 8'hbc, 32'h04);
		wb(0, 8'hb8, 32'h0);
		chk(rd, 32'h0000_0016);
		rq <= 5'h02;
		see_take(3'h1);
		rq <= 5'h10;
		no_take;
		rq <= 5'h14;
		see_take(3'h2);
		wb(0, 8'hc0, 32'h0);
		chk(rd, 32'h0000_0a14);
		no_take;
		rq <= 5'h10;
		repeat (6) @(posedge clk);
		rtn;
		no_take;
		// A return while ce is low must be lost, so serial stays blocked
		ce <= 0;
		rtn;
		no_take;
		ce <= 1;
		rtn;
		see_take(3'h4);
		rq <= 5'h00;
		repeat (6) @(posedge clk);
		rtn;
		stop_test;
	end
endmodule // fspi_ctrl_tb
`default_nettype wire
